// file: hw/csp_pkg.sv
// Constants for the clock selection and power mode controller.
// Assumes a 250 MHz system clock and an APB register port with 32-bit data.
//
// Operation
// - After reset the processor clock selection is the main crystal.
// - The PLL is fed by the main crystal and gives typically 160 MHz.
// - Processor clock sources: main crystal, PLL output or internal 8 MHz oscillator.
// - Selected processor clock passes undivided or through a programmable divider.
// - Real-time clock sources: 32 kHz crystal, crystal/4, RC, 8 MHz, 31.25 kHz.
// - The crystal-derived real-time source is the main crystal divided by four.
// - The 31.25 kHz source is the 8 MHz oscillator divided by 256.
// - Modem-sleep keeps the processor clocked while baseband and radio are off.
// - Light-sleep pauses the processor; wakes on MAC, host, timer or external event.
// - Deep-sleep powers only real-time memory and peripherals; coprocessor stays usable.
// - Hibernation stops 8 MHz oscillator, coprocessor and recovery memory.
// - Hibernation ends only on the real-time timer or real-time pins.
// - A low power-up input forces the powered-off state.
// - With wireless enabled the device alternates between active and modem-sleep.
// - In modem-sleep the processor clock scales with load and peripheral use.
// - Deep-sleep with coprocessor powered keeps pin and two-wire peripherals running.
// - Sensor-monitored deep-sleep runs the converter at a 1% duty cycle.

package csp_pkg;

    // Register byte offsets
    localparam logic [11:0] CSP_CLK_CTRL_OFS = 12'h000;
    localparam logic [11:0] CSP_CPU_DIV_OFS = 12'h004;
    localparam logic [11:0] CSP_PWR_CTRL_OFS = 12'h008;
    localparam logic [11:0] CSP_STATUS_OFS = 12'h00c;

    // Clock control fields
    localparam int CSP_CPU_SEL_LSB = 0;
    localparam int CSP_CPU_DIV_EN_BIT = 2;
    localparam int CSP_RTC_SEL_LSB = 4;
    localparam int CSP_AUTO_SCALE_BIT = 8;

    // Power control fields
    localparam int CSP_SLEEP_MODE_LSB = 0;
    localparam int CSP_SLEEP_GO_BIT = 3;
    localparam int CSP_COPROC_ON_BIT = 4;
    localparam int CSP_SENSOR_PAT_BIT = 5;

    // Status fields
    localparam int CSP_ST_STATE_LSB = 0;
    localparam int CSP_ST_CPU_SEL_LSB = 8;
    localparam int CSP_ST_RTC_SEL_LSB = 12;
    localparam int CSP_ST_CPU_BUSY_BIT = 16;
    localparam int CSP_ST_RTC_BUSY_BIT = 17;

    // Processor clock sources
    localparam logic [1:0] CSP_CPU_XTAL = 2'h0;
    localparam logic [1:0] CSP_CPU_PLL = 2'h1;
    localparam logic [1:0] CSP_CPU_OSC8M = 2'h2;
    localparam int CSP_CPU_NSRC = 3;

    // Real-time clock sources
    localparam logic [2:0] CSP_RTC_XTAL32K = 3'h0;
    localparam logic [2:0] CSP_RTC_XTAL_DIV4 = 3'h1;
    localparam logic [2:0] CSP_RTC_RC = 3'h2;
    localparam logic [2:0] CSP_RTC_OSC8M = 3'h3;
    localparam logic [2:0] CSP_RTC_OSC_DIV256 = 3'h4;
    localparam int CSP_RTC_NSRC = 5;

    // Sleep request codes
    localparam logic [2:0] CSP_SLEEP_LIGHT = 3'h1;
    localparam logic [2:0] CSP_SLEEP_DEEP = 3'h2;
    localparam logic [2:0] CSP_SLEEP_HIBER = 3'h3;

    // Reset values
    localparam logic [1:0] CSP_CPU_SEL_RST = CSP_CPU_XTAL;
    localparam logic [2:0] CSP_RTC_SEL_RST = CSP_RTC_RC;
    localparam logic [7:0] CSP_CPU_DIV_RST = 8'h01;

    // Frequencies and ratios
    localparam int CSP_PLL_OUT_MHZ = 160;
    localparam int CSP_OSC_MHZ = 8;
    localparam int CSP_XTAL_DIV = 4;
    localparam int CSP_OSC_DIV = 256;
    localparam int CSP_XTAL_HALF = CSP_XTAL_DIV / 2;
    localparam int CSP_OSC_HALF = CSP_OSC_DIV / 2;
    localparam int CSP_DUTY_PERCENT = 1;
    localparam int CSP_DUTY_PERIOD = 100 / CSP_DUTY_PERCENT;

    // Power states
    typedef enum logic [5:0] {
        CSP_ST_OFF = 6'b000001,
        CSP_ST_ACTIVE = 6'b000010,
        CSP_ST_MODEM = 6'b000100,
        CSP_ST_LIGHT = 6'b001000,
        CSP_ST_DEEP = 6'b010000,
        CSP_ST_HIBER = 6'b100000
    } csp_state_type;

endpackage : csp_pkg

// file: hw/csp_clock_power.sv
// Clock source selection, dividers and power state sequencer with APB registers.
// Assumes clock source levels arrive as pins and are sampled on sys_clk.
`timescale 1ns/10ps
`default_nettype none

// Glitch-free source switch: gate low on current source, release on new one
module csp_glitch_mux
    import csp_pkg::*;
#(
    parameter int N = 3,
    parameter int SW = 2,
    parameter logic [SW-1:0] RST_SEL = '0
)
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic clkEn,
    input wire logic [N-1:0] srcLevel,
    input wire logic [SW-1:0] selReq,
    output logic clkOut,
    output logic [SW-1:0] selActive,
    output logic busy
);
    logic gated_q;
    logic gated_d;
    logic [SW-1:0] sel_q;
    logic [SW-1:0] sel_d;
    logic out_q;
    wire selValid = (32'(selReq) < N);
    wire pending = selValid && (selReq != sel_q);
    wire curLow = ~srcLevel[sel_q];
    wire newLow = ~srcLevel[selReq];

    // Gate while the current source sits low, hand over while the new one sits low
    always_comb
    begin
        gated_d = gated_q;
        sel_d = sel_q;
        if (!gated_q && pending && curLow)
            gated_d = 1'b1;
        else if (gated_q && newLow)
        begin
            gated_d = 1'b0;
            sel_d = selReq;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            gated_q <= 1'b0;
            sel_q <= RST_SEL;
            out_q <= 1'b0;
        end
        else if (clkEn)
        begin
            gated_q <= gated_d;
            sel_q <= sel_d;
            out_q <= ~gated_d & srcLevel[sel_d];
        end
    end

    assign clkOut = out_q;
    assign selActive = sel_q;
    assign busy = gated_q | pending;
endmodule : csp_glitch_mux

module csp_clock_power
    import csp_pkg::*;
#(
    parameter int ADDR_W = 12,
    parameter int NSYNC = 8
)
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic clkEn,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic xtalClk,
    input wire logic pllClk,
    input wire logic oscClk,
    input wire logic xtal32kClk,
    input wire logic rcClk,
    input wire logic power_up_input,
    input wire logic extIntWake,
    input wire logic rtcGpioWake,
    input wire logic macWake,
    input wire logic hostWake,
    input wire logic rtcTimerWake,
    input wire logic coprocWake,
    input wire logic wirelessEn,
    input wire logic radioBusy,
    input wire logic cpuLoadHigh,
    input wire logic periphBusy,
    output logic cpuClk,
    output logic rtcClk,
    output logic pllEn,
    output logic osc8mEn,
    output logic radioPwr,
    output logic basebandEn,
    output logic cpuRun,
    output logic rtcMemPwr,
    output logic rtcPeriphPwr,
    output logic recoveryMemPwr,
    output logic sleep_coprocessor_en,
    output logic deepPeriphEn,
    output logic sensorAdcEn
);
    // Pin synchronisers, two flops each
    logic [NSYNC-1:0] pinIn;
    logic [NSYNC-1:0] sync1_q;
    logic [NSYNC-1:0] sync2_q;
    assign pinIn = {rtcGpioWake, extIntWake, power_up_input, rcClk, xtal32kClk, oscClk, pllClk, xtalClk};
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++)
        begin : g_sync
            always_ff @(posedge sys_clk or negedge resetn)
            begin
                if (!resetn)
                begin
                    sync1_q[gi] <= 1'b0;
                    sync2_q[gi] <= 1'b0;
                end
                else if (clkEn)
                begin
                    sync1_q[gi] <= pinIn[gi];
                    sync2_q[gi] <= sync1_q[gi];
                end
            end
        end
    endgenerate
    wire xtalS = sync2_q[0];
    wire pllS = sync2_q[1];
    wire oscS = sync2_q[2];
    wire x32S = sync2_q[3];
    wire rcS = sync2_q[4];
    wire powerUpS = sync2_q[5];
    wire extIntS = sync2_q[6];
    wire rtcGpioS = sync2_q[7];

    // Registers
    logic [1:0] cpuSel_q;
    logic cpuDivEn_q;
    logic [2:0] rtcSel_q;
    logic autoScale_q;
    logic [7:0] cpuDiv_q;
    logic [2:0] sleepMode_q;
    logic coprocOn_q;
    logic sensorPat_q;
    logic sleepGo_q;
    logic ready_q;
    logic err_q;
    logic [31:0] rdata_q;
    csp_state_type state_q;
    csp_state_type state_d;

    // APB decode, answer one cycle after setup
    wire setup = psel && !penable && !ready_q;
    wire wrTake = psel && penable && ready_q && pwrite;
    wire hitClk = (paddr == ADDR_W'(CSP_CLK_CTRL_OFS));
    wire hitDiv = (paddr == ADDR_W'(CSP_CPU_DIV_OFS));
    wire hitPwr = (paddr == ADDR_W'(CSP_PWR_CTRL_OFS));
    wire hitSt = (paddr == ADDR_W'(CSP_STATUS_OFS));
    wire hitAny = hitClk || hitDiv || hitPwr || hitSt;
    wire badWr = pwrite && hitSt;
    logic [1:0] cpuAct;
    logic [2:0] rtcAct;
    logic cpuBusy;
    logic rtcBusy;
    logic [31:0] rdMux;
    always_comb
    begin
        rdMux = 32'h0;
        if (hitClk)
        begin
            rdMux[CSP_CPU_SEL_LSB +: 2] = cpuSel_q;
            rdMux[CSP_CPU_DIV_EN_BIT] = cpuDivEn_q;
            rdMux[CSP_RTC_SEL_LSB +: 3] = rtcSel_q;
            rdMux[CSP_AUTO_SCALE_BIT] = autoScale_q;
        end
        else if (hitDiv)
            rdMux[7:0] = cpuDiv_q;
        else if (hitPwr)
        begin
            rdMux[CSP_SLEEP_MODE_LSB +: 3] = sleepMode_q;
            rdMux[CSP_COPROC_ON_BIT] = coprocOn_q;
            rdMux[CSP_SENSOR_PAT_BIT] = sensorPat_q;
        end
        else if (hitSt)
        begin
            rdMux[CSP_ST_STATE_LSB +: 6] = state_q;
            rdMux[CSP_ST_CPU_SEL_LSB +: 2] = cpuAct;
            rdMux[CSP_ST_RTC_SEL_LSB +: 3] = rtcAct;
            rdMux[CSP_ST_CPU_BUSY_BIT] = cpuBusy;
            rdMux[CSP_ST_RTC_BUSY_BIT] = rtcBusy;
        end
    end

    // Bus handshake and register writes; sleep go is a one-cycle pulse
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ready_q <= 1'b0;
            err_q <= 1'b0;
            rdata_q <= 32'h0;
            cpuSel_q <= CSP_CPU_SEL_RST;
            cpuDivEn_q <= 1'b0;
            rtcSel_q <= CSP_RTC_SEL_RST;
            autoScale_q <= 1'b0;
            cpuDiv_q <= CSP_CPU_DIV_RST;
            sleepMode_q <= 3'h0;
            coprocOn_q <= 1'b0;
            sensorPat_q <= 1'b0;
            sleepGo_q <= 1'b0;
        end
        else if (clkEn)
        begin
            ready_q <= setup;
            err_q <= setup && (!hitAny || badWr);
            rdata_q <= (setup && !pwrite) ? rdMux : 32'h0;
            sleepGo_q <= wrTake && hitPwr && pwdata[CSP_SLEEP_GO_BIT];
            if (wrTake && hitClk)
            begin
                cpuSel_q <= pwdata[CSP_CPU_SEL_LSB +: 2];
                cpuDivEn_q <= pwdata[CSP_CPU_DIV_EN_BIT];
                rtcSel_q <= pwdata[CSP_RTC_SEL_LSB +: 3];
                autoScale_q <= pwdata[CSP_AUTO_SCALE_BIT];
            end
            if (wrTake && hitDiv)
                cpuDiv_q <= (pwdata[7:0] == 8'h00) ? 8'h01 : pwdata[7:0];
            if (wrTake && hitPwr)
            begin
                sleepMode_q <= pwdata[CSP_SLEEP_MODE_LSB +: 3];
                coprocOn_q <= pwdata[CSP_COPROC_ON_BIT];
                sensorPat_q <= pwdata[CSP_SENSOR_PAT_BIT];
            end
        end
    end

    // Power state sequencer
    wire sleepLight = sleepGo_q && (sleepMode_q == CSP_SLEEP_LIGHT);
    wire sleepDeep = sleepGo_q && (sleepMode_q == CSP_SLEEP_DEEP);
    wire sleepHiber = sleepGo_q && (sleepMode_q == CSP_SLEEP_HIBER);
    wire lightWake = macWake || hostWake || rtcTimerWake || extIntS;
    wire deepWake = rtcTimerWake || extIntS || rtcGpioS || (coprocOn_q && coprocWake);
    wire hiberWake = rtcTimerWake || rtcGpioS;
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            CSP_ST_OFF:
                if (powerUpS)
                    state_d = CSP_ST_ACTIVE;
            CSP_ST_ACTIVE, CSP_ST_MODEM:
                if (sleepLight)
                    state_d = CSP_ST_LIGHT;
                else if (sleepDeep)
                    state_d = CSP_ST_DEEP;
                else if (sleepHiber)
                    state_d = CSP_ST_HIBER;
                else if (wirelessEn && radioBusy)
                    state_d = CSP_ST_ACTIVE;
                else
                    state_d = CSP_ST_MODEM;
            CSP_ST_LIGHT:
                if (lightWake)
                    state_d = CSP_ST_ACTIVE;
            CSP_ST_DEEP:
                if (deepWake)
                    state_d = CSP_ST_ACTIVE;
            CSP_ST_HIBER:
                if (hiberWake)
                    state_d = CSP_ST_ACTIVE;
            default:
                state_d = CSP_ST_OFF;
        endcase
        if (!powerUpS)
            state_d = CSP_ST_OFF;
    end

    // Domain enables follow the next state, so they change with it
    wire nOff = (state_d == CSP_ST_OFF);
    wire nAct = (state_d == CSP_ST_ACTIVE);
    wire nModem = (state_d == CSP_ST_MODEM);
    wire nLight = (state_d == CSP_ST_LIGHT);
    wire nDeep = (state_d == CSP_ST_DEEP);
    wire nHiber = (state_d == CSP_ST_HIBER);
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_q <= CSP_ST_OFF;
            radioPwr <= 1'b0;
            basebandEn <= 1'b0;
            cpuRun <= 1'b0;
            pllEn <= 1'b0;
            osc8mEn <= 1'b0;
            rtcMemPwr <= 1'b0;
            rtcPeriphPwr <= 1'b0;
            recoveryMemPwr <= 1'b0;
            sleep_coprocessor_en <= 1'b0;
            deepPeriphEn <= 1'b0;
        end
        else if (clkEn)
        begin
            state_q <= state_d;
            radioPwr <= nAct;
            basebandEn <= nAct;
            cpuRun <= nAct || nModem;
            pllEn <= nAct || nModem;
            osc8mEn <= !nOff && !nHiber;
            rtcMemPwr <= !nOff;
            rtcPeriphPwr <= !nOff && !nHiber;
            recoveryMemPwr <= !nOff && !nHiber;
            sleep_coprocessor_en <= nAct || nModem || nLight || (nDeep && coprocOn_q);
            deepPeriphEn <= nDeep && coprocOn_q;
        end
    end

    // Fixed dividers: crystal by 4 and oscillator by 256
    logic xtalPrev_q;
    logic oscPrev_q;
    logic [1:0] xtalCnt_q;
    logic [7:0] oscCnt_q;
    logic xtalDiv4_q;
    logic oscDiv256_q;
    wire oscGated = oscS && osc8mEn; // Oscillator is dead while stopped
    wire xtalRise = xtalS && !xtalPrev_q;
    wire oscRise = oscGated && !oscPrev_q;
    wire xtalWrap = (32'(xtalCnt_q) == CSP_XTAL_HALF - 1);
    wire oscWrap = (32'(oscCnt_q) == CSP_OSC_HALF - 1);
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            xtalPrev_q <= 1'b0;
            oscPrev_q <= 1'b0;
            xtalCnt_q <= 2'h0;
            oscCnt_q <= 8'h00;
            xtalDiv4_q <= 1'b0;
            oscDiv256_q <= 1'b0;
        end
        else if (clkEn)
        begin
            xtalPrev_q <= xtalS;
            oscPrev_q <= oscGated;
            if (xtalRise)
            begin
                xtalCnt_q <= xtalWrap ? 2'h0 : xtalCnt_q + 2'h1;
                xtalDiv4_q <= xtalWrap ? ~xtalDiv4_q : xtalDiv4_q;
            end
            if (oscRise)
            begin
                oscCnt_q <= oscWrap ? 8'h00 : oscCnt_q + 8'h01;
                oscDiv256_q <= oscWrap ? ~oscDiv256_q : oscDiv256_q;
            end
        end
    end

    // Source selectors
    logic cpuMux;
    logic rtcMux;
    csp_glitch_mux #(.N(CSP_CPU_NSRC), .SW(2), .RST_SEL(CSP_CPU_SEL_RST)) u_cpu_mux (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .clkEn(clkEn),
        .srcLevel({oscGated, pllS && pllEn, xtalS}),
        .selReq(cpuSel_q),
        .clkOut(cpuMux),
        .selActive(cpuAct),
        .busy(cpuBusy)
    );
    csp_glitch_mux #(.N(CSP_RTC_NSRC), .SW(3), .RST_SEL(CSP_RTC_SEL_RST)) u_rtc_mux (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .clkEn(clkEn),
        .srcLevel({oscDiv256_q, oscGated, rcS, xtalDiv4_q, x32S}),
        .selReq(rtcSel_q),
        .clkOut(rtcMux),
        .selActive(rtcAct),
        .busy(rtcBusy)
    );

    // Processor divider; modem-sleep scaling, when idle, runs the divider at twice the count
    logic muxPrev_q;
    logic [8:0] divCnt_q;
    logic divOut_q;
    wire autoSlow = (state_q == CSP_ST_MODEM) && autoScale_q && !cpuLoadHigh && !periphBusy;
    wire divOn = cpuDivEn_q || autoSlow;
    wire [8:0] halfCnt = autoSlow ? {cpuDiv_q, 1'b0} : {1'b0, cpuDiv_q};
    wire muxRise = cpuMux && !muxPrev_q;
    wire divWrap = (divCnt_q >= halfCnt - 9'h001);
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            muxPrev_q <= 1'b0;
            divCnt_q <= 9'h000;
            divOut_q <= 1'b0;
            cpuClk <= 1'b0;
        end
        else if (clkEn)
        begin
            muxPrev_q <= cpuMux;
            if (muxRise)
            begin
                divCnt_q <= divWrap ? 9'h000 : divCnt_q + 9'h001;
                divOut_q <= divWrap ? ~divOut_q : divOut_q;
            end
            // Paused processor sees a steady low clock
            cpuClk <= cpuRun && (divOn ? divOut_q : cpuMux);
        end
    end

    // Real-time clock output and converter duty window
    logic rtcPrev_q;
    logic [6:0] dutyCnt_q;
    wire rtcRise = rtcMux && !rtcPrev_q;
    wire dutyWrap = (32'(dutyCnt_q) == CSP_DUTY_PERIOD - 1);
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rtcPrev_q <= 1'b0;
            dutyCnt_q <= 7'h00;
            rtcClk <= 1'b0;
            sensorAdcEn <= 1'b0;
        end
        else if (clkEn)
        begin
            rtcPrev_q <= rtcMux;
            rtcClk <= rtcMux && !nOff;
            if (rtcRise)
                dutyCnt_q <= dutyWrap ? 7'h00 : dutyCnt_q + 7'h01;
            sensorAdcEn <= nDeep && coprocOn_q && sensorPat_q && (dutyCnt_q == 7'h00);
        end
    end

    assign prdata = rdata_q;
    assign pready = ready_q;
    assign pslverr = err_q;
endmodule : csp_clock_power

`default_nettype wire

// file: verif/csp_clock_power_monitor.sv
// Port-level assertions for the clock and power controller.
// Assumes one clock domain and clkEn held high by the bench.
`timescale 1ns/10ps
`default_nettype none

module csp_clock_power_monitor
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic power_up_input,
    input wire logic wirelessEn,
    input wire logic radioBusy,
    input wire logic cpuClk,
    input wire logic cpuRun,
    input wire logic radioPwr,
    input wire logic basebandEn,
    input wire logic osc8mEn,
    input wire logic rtcMemPwr,
    input wire logic recoveryMemPwr,
    input wire logic sleep_coprocessor_en,
    input wire logic deepPeriphEn,
    input wire logic sensorAdcEn
);
    // All checks share the system clock and its reset
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    // Bus answers in the first access cycle, for one cycle only
    a_apb_answer: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held too long");
    a_err_reads_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read returned data");
    // Power states seen through the enables
    a_power_off: assert property (!power_up_input |-> ##[1:4] (!cpuRun && !rtcMemPwr))
        else $error("no power-off after low power-up");
    a_cpu_gated: assert property ((!cpuRun) [*2] |-> !cpuClk)
        else $error("processor clock runs while paused");
    a_modem_radio: assert property (cpuRun && !radioPwr |-> !basebandEn)
        else $error("baseband on without radio");
    a_wireless_active: assert property ((cpuRun && wirelessEn && radioBusy) [*4] |-> radioPwr)
        else $error("radio off while wireless busy");
    a_hiber_off: assert property (!recoveryMemPwr && rtcMemPwr |-> !osc8mEn && !sleep_coprocessor_en)
        else $error("oscillator or coprocessor alive in hibernation");
    a_sensor_deep: assert property (sensorAdcEn |-> !cpuRun && sleep_coprocessor_en && rtcMemPwr)
        else $error("converter on outside deep sleep");
    a_deep_periph: assert property (deepPeriphEn |-> sleep_coprocessor_en && !cpuRun)
        else $error("deep peripherals without coprocessor");
endmodule : csp_clock_power_monitor

bind csp_clock_power csp_clock_power_monitor csp_clock_power_monitor_i (.sys_clk, .resetn, .psel, .penable,
    .pwrite, .prdata, .pready, .pslverr, .power_up_input, .wirelessEn, .radioBusy, .cpuClk, .cpuRun, .radioPwr,
    .basebandEn, .osc8mEn, .rtcMemPwr, .recoveryMemPwr, .sleep_coprocessor_en, .deepPeriphEn, .sensorAdcEn);

`default_nettype wire

// file: verif/csp_clock_power_tb_top.sv
// Self-checking bench for the clock and power controller.
// Assumes APB with one access cycle; source clocks come from a free counter.
`timescale 1ns/10ps
`default_nettype none

module csp_clock_power_tb_top
    import csp_pkg::*;
;
    logic sys_clk, resetn, clkEn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic power_up_input, extIntWake, rtcGpioWake, macWake, hostWake, rtcTimerWake, coprocWake;
    logic wirelessEn, radioBusy, cpuLoadHigh, periphBusy, cpuClk, rtcClk, pllEn, osc8mEn, radioPwr;
    logic basebandEn, cpuRun, rtcMemPwr, rtcPeriphPwr, recoveryMemPwr, sleep_coprocessor_en;
    logic deepPeriphEn, sensorAdcEn, prevC, prevR;
    logic [5:0] cnt;
    int failCount, checkCount, cyc, nC, nR, nS, mC, mR, mS;

    csp_clock_power csp_clock_power_i (.sys_clk, .resetn, .clkEn, .paddr, .psel, .penable, .pwrite, .pwdata,
        .prdata, .pready, .pslverr, .xtalClk(cnt[2]), .pllClk(cnt[0]), .oscClk(cnt[3]), .xtal32kClk(cnt[5]),
        .rcClk(cnt[4]), .power_up_input, .extIntWake, .rtcGpioWake, .macWake, .hostWake, .rtcTimerWake,
        .coprocWake, .wirelessEn, .radioBusy, .cpuLoadHigh, .periphBusy, .cpuClk, .rtcClk, .pllEn, .osc8mEn,
        .radioPwr, .basebandEn, .cpuRun, .rtcMemPwr, .rtcPeriphPwr, .recoveryMemPwr, .sleep_coprocessor_en,
        .deepPeriphEn, .sensorAdcEn);

    // System clock, 4 ns period
    initial
    begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    // Source clocks, edge counters and the hang limit
    always @(posedge sys_clk)
    begin
        cnt <= cnt + 6'h01;
        cyc <= cyc + 1;
        prevC <= cpuClk;
        prevR <= rtcClk;
        nC <= nC + int'(cpuClk && !prevC);
        nR <= nR + int'(rtcClk && !prevR);
        nS <= nS + int'(sensorAdcEn);
        if (cyc == 60000)
        begin
            failCount++;
            report_and_stop();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checkCount++;
        if (seen !== exp)
        begin
            failCount++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // One APB transfer; holds the request until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        // Without pready, only the bench timeout ends this wait
        do
            @(posedge sys_clk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // One idle edge, so a following call never drives psel twice in one step
        @(posedge sys_clk);
    endtask : apb

    task automatic rdChk(input logic [11:0] a, input logic [31:0] mask, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd & mask, exp);
    endtask : rdChk

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : tick

    // Polls status until both source switches have completed
    task automatic settle;
        for (int k = 0; k < 2000; k++)
        begin
            apb(1'b0, CSP_STATUS_OFS, 32'h0);
            if (rd[17:16] === 2'b00)
                break;
        end
    endtask : settle

    task automatic measure(input int len);
        mC = nC;
        mR = nR;
        mS = nS;
        tick(len);
        mC = nC - mC;
        mR = nR - mR;
        mS = nS - mS;
    endtask : measure

    task automatic report_and_stop;
        $display("checks=%0d mismatches=%0d", checkCount, failCount);
        if (failCount == 0 && checkCount > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : report_and_stop

    // Main sequence
    initial
    begin
        {resetn, psel, penable, pwrite, paddr, pwdata, cnt, prevC, prevR} = '0;
        {extIntWake, rtcGpioWake, macWake, hostWake, rtcTimerWake, coprocWake, cpuLoadHigh, periphBusy} = '0;
        {clkEn, power_up_input, wirelessEn, radioBusy} = 4'hf;
        {failCount, checkCount, cyc, nC, nR, nS} = '0;
        tick(20);
        resetn <= 1'b1;
        tick(4);
        rdChk(CSP_CLK_CTRL_OFS, 32'h1ff, 32'h20);
        rdChk(CSP_CPU_DIV_OFS, 32'hff, 32'h1);
        rdChk(CSP_STATUS_OFS, 32'h33f, 32'h2);
        apb(1'b1, 12'h010, 32'h1);
        chk(err, 1);
        apb(1'b1, CSP_STATUS_OFS, 32'h0);
        chk(err, 1);
        rdChk(12'h7fc, 32'hffffffff, 32'h0);
        $display("done reset and bus");
        for (int i = 0; i < CSP_RTC_NSRC; i++)
        begin
            apb(1'b1, CSP_CLK_CTRL_OFS, (i << 4) | (i % CSP_CPU_NSRC));
            settle();
            chk(rd & 32'h7300, (i << 12) | ((i % CSP_CPU_NSRC) << 8));
        end
        apb(1'b1, CSP_CLK_CTRL_OFS, 32'h10);
        settle();
        measure(320);
        chk(mC, 40);
        chk(mR inside {[9:11]}, 1);
        apb(1'b1, CSP_CPU_DIV_OFS, 32'h3);
        apb(1'b1, CSP_CLK_CTRL_OFS, 32'h14);
        settle();
        measure(480);
        chk(mC inside {[9:11]}, 1);
        apb(1'b1, CSP_CLK_CTRL_OFS, 32'h40);
        settle();
        measure(8192);
        chk(mR inside {[1:3]}, 1);
        apb(1'b1, CSP_CLK_CTRL_OFS, 32'h20);
        settle();
        $display("done clock sources");
        apb(1'b1, CSP_PWR_CTRL_OFS, 32'h9);
        tick(4);
        chk({cpuRun, pllEn, rtcMemPwr, rtcPeriphPwr}, 4'b0011);
        rdChk(CSP_STATUS_OFS, 32'h3f, 32'h8);
        hostWake <= 1'b1;
        tick(4);
        chk(cpuRun, 1);
        hostWake <= 1'b0;
        apb(1'b1, CSP_PWR_CTRL_OFS, 32'h3a);
        tick(4);
        chk({cpuRun, radioPwr, rtcMemPwr, sleep_coprocessor_en, deepPeriphEn}, 5'b00111);
        measure(6400);
        chk(mS inside {[32:96]}, 1);
        extIntWake <= 1'b1;
        tick(6);
        chk(cpuRun, 1);
        extIntWake <= 1'b0;
        apb(1'b1, CSP_PWR_CTRL_OFS, 32'hb);
        tick(4);
        chk({osc8mEn, recoveryMemPwr, sleep_coprocessor_en}, 3'b000);
        {macWake, hostWake} <= 2'b11;
        tick(6);
        chk(cpuRun, 0);
        {macWake, hostWake, rtcTimerWake} <= 3'b001;
        tick(6);
        chk(cpuRun, 1);
        rtcTimerWake <= 1'b0;
        $display("done sleep states");
        radioBusy <= 1'b0;
        tick(4);
        chk({radioPwr, basebandEn, cpuRun}, 3'b001);
        rdChk(CSP_STATUS_OFS, 32'h3f, 32'h4);
        apb(1'b1, CSP_CLK_CTRL_OFS, 32'h120);
        measure(960);
        chk(mC inside {[9:11]}, 1);
        cpuLoadHigh <= 1'b1;
        measure(320);
        chk(mC inside {[39:41]}, 1);
        radioBusy <= 1'b1;
        tick(4);
        chk(radioPwr, 1);
        power_up_input <= 1'b0;
        tick(6);
        chk({cpuRun, rtcMemPwr}, 2'b00);
        rdChk(CSP_STATUS_OFS, 32'h3f, 32'h1);
        power_up_input <= 1'b1;
        tick(6);
        chk(cpuRun, 1);
        apb(1'b1, CSP_CLK_CTRL_OFS, 32'h1);
        resetn <= 1'b0;
        tick(2);
        resetn <= 1'b1;
        tick(4);
        rdChk(CSP_CLK_CTRL_OFS, 32'h1ff, 32'h20);
        $display("done modem, power-off and second reset");
        report_and_stop();
    end
endmodule : csp_clock_power_tb_top

`default_nettype wire
